// >>> common/srm_pkg.sv
// Constants, register map and enumerations for the synthesizer reference and monitor registers
package srm_pkg;
    // Serial frame: read/write flag, 15-bit address, 8-bit data, MSB first
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam int CNT_W = 5;
    localparam int COEF_W = 16;
    localparam logic [4:0] HEAD_LEN = 5'h10;
    localparam logic [4:0] FRAME_LEN = 5'h18;
    localparam int RW_BIT = 15;

    // Register addresses
    localparam logic [14:0] ADDR_REF_DIV = 15'h001F;
    localparam logic [14:0] ADDR_MON_CTRL = 15'h0020;
    localparam logic [14:0] ADDR_REF_IN = 15'h0022;
    localparam logic [14:0] ADDR_TRK_CTRL = 15'h0023;
    localparam logic [14:0] ADDR_OUT_DIV = 15'h0024;
    localparam logic [14:0] ADDR_COEF_LO = 15'h0070;
    localparam logic [14:0] ADDR_COEF_HI = 15'h0071;

    // Reset values
    localparam logic [7:0] RST_REF_DIV = 8'h01;
    localparam logic [7:0] RST_MON_CTRL = 8'h14;
    localparam logic [7:0] RST_REF_IN = 8'h00;
    localparam logic [7:0] RST_TRK_CTRL = 8'h00;
    localparam logic [7:0] RST_OUT_DIV = 8'h80;
    localparam logic [7:0] RST_COEF = 8'h00;

    // Writable bits; reserved bits are never stored and read as zero
    localparam logic [7:0] MASK_REF_DIV = 8'h1F;
    localparam logic [7:0] MASK_MON_CTRL = 8'hFC;
    localparam logic [7:0] MASK_REF_IN = 8'h70;
    localparam logic [7:0] MASK_TRK_CTRL = 8'h32;
    localparam logic [7:0] MASK_OUT_DIV = 8'hF0;
    localparam logic [7:0] MASK_COEF = 8'hFF;

    // Field positions
    localparam int R_WORD_HI = 4;
    localparam int MON_SEL_HI = 7;
    localparam int MON_SEL_LO = 4;
    localparam int MON_EN_BIT = 3;
    localparam int MON_LEV_BIT = 2;
    localparam int REF_TYPE_BIT = 6;
    localparam int REF_FREQUENCY_DOUBLER_BIT = 5;
    localparam int REF_HALVE_BIT = 4;
    localparam int CLK_DIV_HI = 5;
    localparam int CLK_DIV_LO = 4;
    localparam int TRK_SRC_BIT = 1;
    localparam int OUT_DIV_HI = 7;
    localparam int OUT_DIV_LO = 4;

    // Synchronised pin indices
    localparam int PIN_W = 9;
    localparam int PIN_LOCK = 0;
    localparam int PIN_UP = 1;
    localparam int PIN_DN = 2;
    localparam int PIN_OSC = 3;
    localparam int PIN_CAL_REF = 4;
    localparam int PIN_CAL_FB = 5;
    localparam int PIN_FB = 6;
    localparam int PIN_REF = 7;
    localparam int PIN_HOLD = 8;

    // Monitor pin selections
    typedef enum logic [3:0] {
        MON_HIZ = 4'h0,
        MON_LOCK = 4'h1,
        MON_PUMP_UP = 4'h2,
        MON_PUMP_DN = 4'h3,
        MON_REF_HALF = 4'h4,
        MON_FB_HALF = 4'h5,
        MON_OSC_TEST = 4'h6,
        MON_RSVD = 4'h7,
        MON_HIGH = 4'h8,
        MON_CAL_REF = 4'h9,
        MON_CAL_FB = 4'hA
    } srm_mon_sel_type;

    // Serial frame states
    typedef enum logic [1:0] {
        SPI_IDLE = 2'b00,
        SPI_HEAD = 2'b01,
        SPI_DATA = 2'b10,
        SPI_DONE = 2'b11
    } srm_spi_state_type;
endpackage : srm_pkg

// >>> common/srm_ref_if.sv
// Carrier between the register logic and the reference path
`timescale 1ns/10ps
interface srm_ref_if;
    logic ref_level;
    logic doubler_en;
    logic halve_en;
    logic hold;
    logic [4:0] r_word;
    logic pfd_clk;
    logic ref_half;

    modport ctrl (output ref_level, output doubler_en, output halve_en, output hold, output r_word,
                  input pfd_clk, input ref_half);
    modport path (input ref_level, input doubler_en, input halve_en, input hold, input r_word,
                  output pfd_clk, output ref_half);
endinterface : srm_ref_if

// >>> hw/srm_ref_path.sv
// Reference path: optional doubler, reference counter, optional halving stage
`timescale 1ns/10ps
module srm_ref_path (
    input wire logic mclk_i,
    input wire logic rst_i,
    srm_ref_if.path rif
);
    typedef struct packed {
        logic ref_d;
        logic [4:0] cnt;
        logic half;
        logic phase_freq_detector;
    } srm_path_state_type;

    srm_path_state_type st;
    srm_path_state_type next_st;

    assign rif.pfd_clk = st.phase_freq_detector;
    assign rif.ref_half = st.half;

    // Doubler feeds the counter, counter feeds the halving stage
    always_comb begin
        logic pulse;
        logic terminal;
        logic [4:0] limit;
        pulse = 1'b0;
        terminal = 1'b0;
        limit = 5'h01;
        next_st = st;
        next_st.ref_d = rif.ref_level;
        // Both edges count when doubling, so the counter sees twice the reference rate
        pulse = (rif.ref_level & ~st.ref_d) | (rif.doubler_en & ~rif.ref_level & st.ref_d); // [R9] [R15]
        // A zero count word would wrap and divide by 32; treat it as divide by one
        limit = (rif.r_word == 5'h00) ? 5'h01 : rif.r_word; // [R1]
        if (rif.hold) begin
            next_st.cnt = 5'h00; // [R14]
            next_st.half = 1'b0;
            next_st.phase_freq_detector = 1'b0;
        end else begin
            if (pulse) begin
                if (st.cnt == limit - 5'h01) begin
                    next_st.cnt = 5'h00;
                    terminal = 1'b1;
                end else begin
                    next_st.cnt = st.cnt + 5'h01;
                end
            end
            if (terminal) begin
                next_st.half = ~st.half;
            end
            // Toggling gives an even duty cycle; without it the detector sees one-cycle pulses
            if (rif.halve_en) begin
                next_st.phase_freq_detector = terminal ? ~st.phase_freq_detector : st.phase_freq_detector; // [R10] [R11] [R15]
            end else begin
                next_st.phase_freq_detector = terminal;
            end
        end
    end

    // State register
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : srm_ref_path

// >>> hw/srm_regs.sv
// Serial-port register bank for reference path, monitor pin and tracking filter source
//
// Notes on behaviour
// R1: Five-bit reference count word, resets to one
// R2: Four-bit selector picks monitor pin source
// R3: High impedance only while monitor disabled
// R4: Monitor disabled: pin carries serial read data
// R5: Monitor enabled: pin carries selected signal
// R6: Software keeps monitor disabled for reads
// R7: Level bit picks 1.8 V or 3.3 V
// R8: Bit 6 picks single-ended or differential input
// R9: Bit 5 enables the reference doubler
// R10: Bit 4 enables the reference halving stage
// R11: Halving stage gives even duty cycle
// R12: Source bit zero: automatic filter coefficients
// R13: Source bit one: coefficients from two registers
// R14: Hold bit resets feedback and reference counters
// R15: Doubler, then counter, then halving stage
`timescale 1ns/10ps
module srm_regs (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sdi_i,
    output logic muxout_o,
    output logic muxout_oe_n_o,
    output logic monitor_logic_level_o,
    input wire logic ref_clk_i,
    input wire logic divider_hold_reset_i,
    input wire logic lock_detect_i,
    input wire logic pump_up_i,
    input wire logic pump_dn_i,
    input wire logic osc_test_i,
    input wire logic cal_ref_band_i,
    input wire logic cal_fb_band_i,
    input wire logic fb_div_i,
    input wire logic [15:0] auto_coef_i,
    output logic [15:0] track_coef_o,
    output logic ref_input_type_o,
    output logic pfd_clk_o,
    output logic [3:0] fb_div_sel_o,
    output logic [1:0] clk_div_mode_o
);
    typedef struct packed {
        logic cs_s1;
        logic cs_s2;
        logic sck_s1;
        logic sck_s2;
        logic sck_s3;
        logic sdi_s1;
        logic sdi_s2;
        logic [srm_pkg::PIN_W-1:0] pin_s1;
        logic [srm_pkg::PIN_W-1:0] pin_s2;
        logic fb_d;
        logic fb_half;
        srm_pkg::srm_spi_state_type state;
        logic [4:0] bitcnt;
        logic [23:0] shreg;
        logic is_read;
        logic [7:0] tx;
        logic sdo;
        logic [7:0] ref_div;
        logic [7:0] mon_ctrl;
        logic [7:0] ref_in;
        logic [7:0] trk_ctrl;
        logic [7:0] out_div;
        logic [7:0] coef_lo;
        logic [7:0] coef_hi;
        logic mux_pin;
        logic mux_oe_n;
        logic [15:0] coef_out;
        logic pfd_out;
    } srm_regs_state_type;

    srm_regs_state_type st;
    srm_regs_state_type next_st;
    srm_ref_if rif ();

    // Reference path configuration from the registers; reference level and hold from the synchronised pins
    assign rif.ref_level = st.pin_s2[srm_pkg::PIN_REF];
    assign rif.doubler_en = st.ref_in[srm_pkg::REF_FREQUENCY_DOUBLER_BIT]; // [R9]
    assign rif.halve_en = st.ref_in[srm_pkg::REF_HALVE_BIT]; // [R10]
    assign rif.hold = st.pin_s2[srm_pkg::PIN_HOLD]; // [R14]
    assign rif.r_word = st.ref_div[srm_pkg::R_WORD_HI:0]; // [R1]

    srm_ref_path u_path (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .rif(rif.path)
    );

    // Outputs, each from a register bit
    assign muxout_o = st.mux_pin;
    assign muxout_oe_n_o = st.mux_oe_n;
    assign monitor_logic_level_o = st.mon_ctrl[srm_pkg::MON_LEV_BIT]; // [R7]
    assign ref_input_type_o = st.ref_in[srm_pkg::REF_TYPE_BIT]; // [R8]
    assign track_coef_o = st.coef_out;
    assign pfd_clk_o = st.pfd_out;
    assign fb_div_sel_o = st.out_div[srm_pkg::OUT_DIV_HI:srm_pkg::OUT_DIV_LO];
    assign clk_div_mode_o = st.trk_ctrl[srm_pkg::CLK_DIV_HI:srm_pkg::CLK_DIV_LO];

    // Serial decode, register update and monitor pin steering
    always_comb begin
        logic rise;
        logic fall;
        logic [23:0] nshift;
        logic [14:0] raddr;
        logic [7:0] rd;
        logic [7:0] wd;
        logic [14:0] waddr;
        rise = 1'b0;
        fall = 1'b0;
        nshift = '0;
        raddr = '0;
        rd = 8'h00;
        wd = 8'h00;
        waddr = '0;
        next_st = st;

        // Two-stage synchronisers; logic reads the second stage, and the serial clock's third stage for edge detection
        next_st.cs_s1 = spi_cs_n_i;
        next_st.cs_s2 = st.cs_s1;
        next_st.sck_s1 = spi_sclk_i;
        next_st.sck_s2 = st.sck_s1;
        next_st.sck_s3 = st.sck_s2;
        next_st.sdi_s1 = spi_sdi_i;
        next_st.sdi_s2 = st.sdi_s1;
        next_st.pin_s1 = {divider_hold_reset_i, ref_clk_i, fb_div_i, cal_fb_band_i, cal_ref_band_i,
                          osc_test_i, pump_dn_i, pump_up_i, lock_detect_i};
        next_st.pin_s2 = st.pin_s1;

        // Feedback halving for the monitor, held while the counters are held
        next_st.fb_d = st.pin_s2[srm_pkg::PIN_FB];
        if (st.pin_s2[srm_pkg::PIN_HOLD]) begin
            next_st.fb_half = 1'b0; // [R14]
        end else if (st.pin_s2[srm_pkg::PIN_FB] & ~st.fb_d) begin
            next_st.fb_half = ~st.fb_half;
        end

        rise = st.sck_s2 & ~st.sck_s3;
        fall = ~st.sck_s2 & st.sck_s3;
        nshift = {st.shreg[22:0], st.sdi_s2};
        raddr = nshift[srm_pkg::ADDR_W-1:0];
        wd = nshift[srm_pkg::DATA_W-1:0];
        waddr = nshift[srm_pkg::ADDR_W+srm_pkg::DATA_W-1:srm_pkg::DATA_W];

        // Read data selection; unmapped addresses read as zero
        if (raddr == srm_pkg::ADDR_REF_DIV) begin
            rd = st.ref_div;
        end else if (raddr == srm_pkg::ADDR_MON_CTRL) begin
            rd = st.mon_ctrl;
        end else if (raddr == srm_pkg::ADDR_REF_IN) begin
            rd = st.ref_in;
        end else if (raddr == srm_pkg::ADDR_TRK_CTRL) begin
            rd = st.trk_ctrl;
        end else if (raddr == srm_pkg::ADDR_OUT_DIV) begin
            rd = st.out_div;
        end else if (raddr == srm_pkg::ADDR_COEF_LO) begin
            rd = st.coef_lo;
        end else if (raddr == srm_pkg::ADDR_COEF_HI) begin
            rd = st.coef_hi;
        end else begin
            rd = 8'h00;
        end

        // Frame sequencer; raising chip select abandons any partial frame
        if (st.cs_s2) begin
            next_st.state = srm_pkg::SPI_IDLE;
            next_st.bitcnt = 5'h00;
            next_st.is_read = 1'b0;
            next_st.sdo = 1'b0;
        end else begin
            case (st.state)
                srm_pkg::SPI_IDLE: begin
                    next_st.state = srm_pkg::SPI_HEAD;
                    next_st.bitcnt = 5'h00;
                end
                srm_pkg::SPI_HEAD: begin
                    if (rise) begin
                        next_st.shreg = nshift;
                        next_st.bitcnt = st.bitcnt + 5'h01;
                        if (st.bitcnt == srm_pkg::HEAD_LEN - 5'h01) begin
                            next_st.state = srm_pkg::SPI_DATA;
                            next_st.is_read = nshift[srm_pkg::RW_BIT];
                            next_st.tx = rd;
                        end
                    end
                end
                srm_pkg::SPI_DATA: begin
                    if (fall && st.is_read) begin
                        next_st.sdo = st.tx[7];
                        next_st.tx = {st.tx[6:0], 1'b0};
                    end
                    if (rise) begin
                        next_st.shreg = nshift;
                        next_st.bitcnt = st.bitcnt + 5'h01;
                        if (st.bitcnt == srm_pkg::FRAME_LEN - 5'h01) begin
                            next_st.state = srm_pkg::SPI_DONE;
                            // Writes land only on the last data bit; reserved bits are masked off
                            if (!nshift[srm_pkg::RW_BIT + srm_pkg::DATA_W]) begin
                                if (waddr == srm_pkg::ADDR_REF_DIV) begin
                                    next_st.ref_div = wd & srm_pkg::MASK_REF_DIV; // [R1]
                                end else if (waddr == srm_pkg::ADDR_MON_CTRL) begin
                                    next_st.mon_ctrl = wd & srm_pkg::MASK_MON_CTRL; // [R2] [R7]
                                end else if (waddr == srm_pkg::ADDR_REF_IN) begin
                                    next_st.ref_in = wd & srm_pkg::MASK_REF_IN; // [R8] [R9] [R10]
                                end else if (waddr == srm_pkg::ADDR_TRK_CTRL) begin
                                    next_st.trk_ctrl = wd & srm_pkg::MASK_TRK_CTRL;
                                end else if (waddr == srm_pkg::ADDR_OUT_DIV) begin
                                    next_st.out_div = wd & srm_pkg::MASK_OUT_DIV;
                                end else if (waddr == srm_pkg::ADDR_COEF_LO) begin
                                    next_st.coef_lo = wd & srm_pkg::MASK_COEF; // [R13]
                                end else if (waddr == srm_pkg::ADDR_COEF_HI) begin
                                    next_st.coef_hi = wd & srm_pkg::MASK_COEF; // [R13]
                                end
                            end
                        end
                    end
                end
                default: begin
                    // Extra clocks after a full frame are ignored
                    next_st.state = srm_pkg::SPI_DONE;
                end
            endcase
        end

        // Monitor pin: selected source when enabled, else serial read data
        if (st.mon_ctrl[srm_pkg::MON_EN_BIT]) begin
            next_st.mux_oe_n = 1'b0; // [R5]
            case (st.mon_ctrl[srm_pkg::MON_SEL_HI:srm_pkg::MON_SEL_LO]) // [R2]
                srm_pkg::MON_HIZ: next_st.mux_pin = 1'b0; // [R3]
                srm_pkg::MON_LOCK: next_st.mux_pin = st.pin_s2[srm_pkg::PIN_LOCK];
                srm_pkg::MON_PUMP_UP: next_st.mux_pin = st.pin_s2[srm_pkg::PIN_UP];
                srm_pkg::MON_PUMP_DN: next_st.mux_pin = st.pin_s2[srm_pkg::PIN_DN];
                srm_pkg::MON_REF_HALF: next_st.mux_pin = rif.ref_half;
                srm_pkg::MON_FB_HALF: next_st.mux_pin = st.fb_half;
                srm_pkg::MON_OSC_TEST: next_st.mux_pin = st.pin_s2[srm_pkg::PIN_OSC];
                srm_pkg::MON_HIGH: next_st.mux_pin = 1'b1;
                srm_pkg::MON_CAL_REF: next_st.mux_pin = st.pin_s2[srm_pkg::PIN_CAL_REF];
                srm_pkg::MON_CAL_FB: next_st.mux_pin = st.pin_s2[srm_pkg::PIN_CAL_FB];
                default: next_st.mux_pin = 1'b0;
            endcase
        end else begin
            // Released to high impedance outside the data phase of a read
            next_st.mux_pin = st.sdo; // [R4] [R6]
            next_st.mux_oe_n = ~(st.is_read && (st.state == srm_pkg::SPI_DATA) && !st.cs_s2); // [R3] [R4]
        end

        // Coefficient source select
        next_st.coef_out = st.trk_ctrl[srm_pkg::TRK_SRC_BIT] ? {st.coef_hi, st.coef_lo} : auto_coef_i; // [R12] [R13]
        next_st.pfd_out = rif.pfd_clk; // [R15]
    end

    // State register; chip select synchroniser idles deasserted
    always_ff @(posedge mclk_i or posedge rst_i) begin
        if (rst_i) begin
            st <= '0;
            st.cs_s1 <= 1'b1;
            st.cs_s2 <= 1'b1;
            st.mux_oe_n <= 1'b1;
            st.ref_div <= srm_pkg::RST_REF_DIV;
            st.mon_ctrl <= srm_pkg::RST_MON_CTRL;
            st.ref_in <= srm_pkg::RST_REF_IN;
            st.trk_ctrl <= srm_pkg::RST_TRK_CTRL;
            st.out_div <= srm_pkg::RST_OUT_DIV;
            st.coef_lo <= srm_pkg::RST_COEF;
            st.coef_hi <= srm_pkg::RST_COEF;
        end else begin
            st <= next_st;
        end
    end
endmodule : srm_regs

// >>> verif/srm_regs_assertions.sv
// Port-level assertions for the serial register bank
`timescale 1ns/10ps
module srm_regs_checker (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic spi_sclk_i,
    input wire logic spi_cs_n_i,
    input wire logic spi_sdi_i,
    input wire logic muxout_o,
    input wire logic muxout_oe_n_o,
    input wire logic monitor_logic_level_o,
    input wire logic ref_clk_i,
    input wire logic divider_hold_reset_i,
    input wire logic lock_detect_i,
    input wire logic pump_up_i,
    input wire logic pump_dn_i,
    input wire logic osc_test_i,
    input wire logic cal_ref_band_i,
    input wire logic cal_fb_band_i,
    input wire logic fb_div_i,
    input wire logic [15:0] auto_coef_i,
    input wire logic [15:0] track_coef_o,
    input wire logic ref_input_type_o,
    input wire logic pfd_clk_o,
    input wire logic [3:0] fb_div_sel_o,
    input wire logic [1:0] clk_div_mode_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (rst_i);

    // Outputs leave reset at their defaults
    property p_reset_vals;
        $fell(rst_i) |-> muxout_oe_n_o && monitor_logic_level_o && !ref_input_type_o && fb_div_sel_o == 4'h8;
    endproperty
    a_reset_vals: assert property (p_reset_vals) else $error("Outputs wrong after reset");
    // Hold pin silences the detector clock once synchronised
    property p_hold;
        divider_hold_reset_i [*5] |-> !pfd_clk_o;
    endproperty
    a_hold: assert property (p_hold) else $error("Detector clock active during hold");
    // No reference edge, no detector clock activity
    property p_ref_quiet;
        ($stable(ref_clk_i) && spi_cs_n_i && !divider_hold_reset_i) [*8] |=> $stable(pfd_clk_o);
    endproperty
    a_ref_quiet: assert property (p_ref_quiet) else $error("Detector clock moved without reference");
    // Configuration outputs move only through serial writes
    property p_level;
        spi_cs_n_i [*8] |=> $stable(monitor_logic_level_o);
    endproperty
    a_level: assert property (p_level) else $error("Level output changed while idle");
    property p_ref_type;
        spi_cs_n_i [*8] |=> $stable(ref_input_type_o);
    endproperty
    a_ref_type: assert property (p_ref_type) else $error("Input type changed while idle");
    property p_fb_sel;
        spi_cs_n_i [*8] |=> $stable(fb_div_sel_o) && $stable(clk_div_mode_o);
    endproperty
    a_fb_sel: assert property (p_fb_sel) else $error("Divider fields changed while idle");
    // Pin driver turns on only during a read frame or after a write
    property p_oe;
        spi_cs_n_i [*8] |=> !$fell(muxout_oe_n_o);
    endproperty
    a_oe: assert property (p_oe) else $error("Pin driver enabled while idle");
    // Coefficients hold while neither source moves
    property p_track;
        ($stable(auto_coef_i) && spi_cs_n_i) [*4] |=> $stable(track_coef_o);
    endproperty
    a_track: assert property (p_track) else $error("Coefficients moved without cause");

    c_oe: cover property ($fell(muxout_oe_n_o));
    c_pfd: cover property ($rose(pfd_clk_o));
    c_hold: cover property (divider_hold_reset_i [*5]);
endmodule : srm_regs_checker

bind srm_regs srm_regs_checker srm_regs_checker_i (.*);

// >>> verif/testbench.sv
// Self-checking bench for the serial register bank
`timescale 1ns/10ps
module testbench;
    logic mclk_i = 1'b0;
    logic rst_i = 1'b1;
    logic spi_sclk_i = 1'b0;
    logic spi_cs_n_i = 1'b1;
    logic spi_sdi_i = 1'b0;
    logic ref_clk_i = 1'b0;
    logic divider_hold_reset_i = 1'b0;
    logic [5:0] mon_src = 6'h00; // Cal feedback, cal reference, osc, down, up, lock
    logic [15:0] auto_coef_i = 16'h0000;
    logic muxout_o, muxout_oe_n_o, monitor_logic_level_o, ref_input_type_o, pfd_clk_o;
    logic [15:0] track_coef_o;
    logic [3:0] fb_div_sel_o;
    logic [1:0] clk_div_mode_o;
    logic ref_run = 1'b0;
    int ref_cnt = 0;
    int fail_count = 0;
    int samples_checked = 0;

    srm_regs srm_regs_i (.mclk_i(mclk_i), .rst_i(rst_i), .spi_sclk_i(spi_sclk_i), .spi_cs_n_i(spi_cs_n_i),
        .spi_sdi_i(spi_sdi_i), .muxout_o(muxout_o), .muxout_oe_n_o(muxout_oe_n_o),
        .monitor_logic_level_o(monitor_logic_level_o), .ref_clk_i(ref_clk_i),
        .divider_hold_reset_i(divider_hold_reset_i), .lock_detect_i(mon_src[0]), .pump_up_i(mon_src[1]),
        .pump_dn_i(mon_src[2]), .osc_test_i(mon_src[3]), .cal_ref_band_i(mon_src[4]), .cal_fb_band_i(mon_src[5]),
        .fb_div_i(1'b0), .auto_coef_i(auto_coef_i), .track_coef_o(track_coef_o),
        .ref_input_type_o(ref_input_type_o), .pfd_clk_o(pfd_clk_o), .fb_div_sel_o(fb_div_sel_o),
        .clk_div_mode_o(clk_div_mode_o));

    always #5 mclk_i = ~mclk_i;

    // Reference pin toggles every 5 cycles, well under the sync limit
    always @(posedge mclk_i) begin
        if (ref_run) begin
            ref_cnt <= (ref_cnt == 4) ? 0 : ref_cnt + 1;
            if (ref_cnt == 4) ref_clk_i <= ~ref_clk_i;
        end
    end

    task automatic tick(input int n);
        repeat (n) @(posedge mclk_i);
    endtask : tick

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // One frame; sclk low for 7 cycles and high for 6 keeps clear of the synchroniser limit
    task automatic spi(input logic rd, input logic [14:0] a, input logic [7:0] v, output logic [7:0] d);
        logic [23:0] f;
        f = {rd, a, v};
        d = 8'h00;
        spi_cs_n_i <= 1'b0;
        tick(6);
        for (int i = 23; i >= 0; i--) begin
            spi_sclk_i <= 1'b0;
            spi_sdi_i <= f[i];
            tick(6);
            @(negedge mclk_i);
            d = {d[6:0], muxout_o};
            tick(1);
            spi_sclk_i <= 1'b1;
            tick(6);
        end
        spi_cs_n_i <= 1'b1;
        spi_sclk_i <= 1'b0;
        tick(10);
    endtask : spi

    task automatic wr(input logic [14:0] a, input logic [7:0] v);
        logic [7:0] d;
        spi(1'b0, a, v, d);
    endtask : wr

    // Reads only with the monitor disabled so the pin returns data
    task automatic rd_chk(input logic [14:0] a, input logic [7:0] exp);
        logic [7:0] d;
        spi(1'b1, a, 8'h00, d);
        check(d, exp, "register read");
    endtask : rd_chk

    task automatic test_map();
        logic [14:0] a [7] = '{15'h1F, 15'h20, 15'h22, 15'h23, 15'h24, 15'h70, 15'h71};
        logic [7:0] m [7] = '{8'h1F, 8'hFC, 8'h70, 8'h32, 8'hF0, 8'hFF, 8'hFF};
        logic [7:0] r [7] = '{8'h01, 8'h14, 8'h00, 8'h00, 8'h80, 8'h00, 8'h00};
        for (int i = 0; i < 7; i++) rd_chk(a[i], r[i]);
        check({muxout_oe_n_o, monitor_logic_level_o, ref_input_type_o, fb_div_sel_o}, 7'h68, "reset pins");
        for (int i = 0; i < 7; i++) begin
            wr(a[i], 8'hF7);
            rd_chk(a[i], 8'hF7 & m[i]);
        end
        check({monitor_logic_level_o, ref_input_type_o, fb_div_sel_o, clk_div_mode_o}, 8'hFF, "set pins");
        check(track_coef_o, 16'hF7F7, "manual coefficients");
        wr(15'h20, 8'h10);
        wr(15'h22, 8'h00);
        check({monitor_logic_level_o, ref_input_type_o}, 2'b00, "cleared pins");
        wr(15'h21, 8'hFF);
        rd_chk(15'h21, 8'h00);
        for (int i = 0; i < 7; i++) wr(a[i], r[i]);
    endtask : test_map

    task automatic test_track();
        auto_coef_i <= 16'hA5C3;
        tick(3);
        check(track_coef_o, 16'hA5C3, "auto coefficients");
        wr(15'h70, 8'h34);
        wr(15'h71, 8'h12);
        wr(15'h23, 8'h02);
        auto_coef_i <= 16'h5A3C;
        tick(3);
        check(track_coef_o, 16'h1234, "manual coefficients");
        wr(15'h23, 8'h00);
        check(track_coef_o, 16'h5A3C, "auto coefficients");
    endtask : test_track

    // Each source alone high, then alone low, so swapped selections show
    task automatic test_monitor();
        logic [3:0] codes [6] = '{4'h1, 4'h2, 4'h3, 4'h6, 4'h9, 4'hA};
        logic [7:0] d;
        for (int i = 0; i < 6; i++) begin
            wr(15'h20, {codes[i], 4'hC});
            mon_src <= 6'h01 << i;
            tick(6);
            check({muxout_oe_n_o, muxout_o}, 2'b01, "monitor high");
            mon_src <= ~(6'h01 << i);
            tick(6);
            check({muxout_oe_n_o, muxout_o}, 2'b00, "monitor low");
        end
        mon_src <= 6'h3F;
        wr(15'h20, 8'h0C);
        check({muxout_oe_n_o, muxout_o}, 2'b00, "code zero enabled");
        wr(15'h20, 8'h7C);
        check({muxout_oe_n_o, muxout_o}, 2'b00, "reserved code");
        mon_src <= 6'h00;
        wr(15'h20, 8'h8C);
        spi(1'b1, 15'h20, 8'h00, d);
        check(d, 8'hFF, "pin kept on monitor");
        wr(15'h20, 8'h14);
        check(muxout_oe_n_o, 1'b1, "pin released");
    endtask : test_monitor

    task automatic pfd_gap(output int n);
        logic v;
        v = pfd_clk_o;
        n = 0;
        while (pfd_clk_o === v) begin
            @(negedge mclk_i);
            n++;
            if (n > 400) begin
                fail_count++;
                $display("[FAIL] %0t detector clock stuck", $time);
                give_verdict();
            end
        end
    endtask : pfd_gap

    // High and low widths after settling; starts on a rising edge
    task automatic pfd_expect(input int hi, input int lo);
        int n;
        tick(40);
        @(negedge mclk_i);
        pfd_gap(n);
        if (pfd_clk_o !== 1'b1) pfd_gap(n);
        pfd_gap(n);
        check(16'(n), 16'(hi), "detector high time");
        pfd_gap(n);
        check(16'(n), 16'(lo), "detector low time");
        tick(1);
    endtask : pfd_expect

    task automatic test_ref();
        wr(15'h1F, 8'h03);
        ref_run <= 1'b1;
        pfd_expect(1, 29);
        wr(15'h22, 8'h20);
        pfd_expect(1, 14);
        wr(15'h22, 8'h10);
        pfd_expect(30, 30);
        divider_hold_reset_i <= 1'b1;
        tick(8);
        for (int i = 0; i < 50; i++) begin
            @(negedge mclk_i);
            check(pfd_clk_o, 1'b0, "held detector clock");
        end
        tick(1);
        divider_hold_reset_i <= 1'b0;
        pfd_expect(30, 30);
        // Hold cleared both halving stages together, so the halved divider on the pin tracks the detector clock
        wr(15'h20, 8'h4C);
        for (int i = 0; i < 60; i++) begin
            @(negedge mclk_i);
            check(muxout_o, pfd_clk_o, "reference half on pin");
        end
        ref_run <= 1'b0;
    endtask : test_ref

    task automatic give_verdict();
        $display("Checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : give_verdict

    initial begin
        tick(6);
        rst_i <= 1'b0;
        tick(4);
        test_map();
        test_track();
        test_monitor();
        test_ref();
        give_verdict();
    end
endmodule : testbench
